/* File: rtl/quad_serial_buffers.sv */
// Transmit queue, receive FIFO and interrupt signal enables of the quad serial interface
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`include "qsi_buffers_regs.svh"
module quad_serial_buffers #(
	parameter int DEPTH = `QUEUE_DEPTH,
	parameter int TX_THRESHOLD = 4,
	parameter int RX_THRESHOLD = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output qsi_buffers_pkg::word_t loadWord,
	input wire logic loadTaken,
	input wire logic [31:0] shiftIn,
	input wire logic transferDone,
	input wire qsi_buffers_pkg::ext_events_t events,
	output logic [`SIG_EN_BITS-1:0] intSignals,
	output logic irq
);
	import qsi_buffers_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0] txMem [DEPTH];
	logic [31:0] rxMem [DEPTH];
	logic [31:0] next_txMem [DEPTH];
	logic [31:0] next_rxMem [DEPTH];
	logic [AW-1:0] txRd, txWr, rxRd, rxWr;
	logic [AW-1:0] next_txRd, next_txWr, next_rxRd, next_rxWr;
	logic [AW:0] txCount, rxCount, next_txCount, next_rxCount;
	logic [31:0] txLast, next_txLast;
	logic [31:0] rxHead, next_rxHead;
	logic [`SIG_EN_BITS-1:0] sigEn, next_sigEn;
	logic [`SIG_EN_BITS-1:0] intStatus, next_intStatus;
	logic [`SIG_EN_BITS-1:0] intMask, next_intMask;
	logic [`SIG_EN_BITS-1:0] cond;
	logic [7:0] awAddrHold, next_awAddrHold;
	logic awHave, next_awHave;
	logic [31:0] wDataHold, next_wDataHold;
	logic [3:0] wStrbHold, next_wStrbHold;
	logic wHave, next_wHave;
	logic bvalidR, next_bvalidR;
	logic [1:0] brespR, next_brespR;
	logic rvalidR, next_rvalidR;
	logic [31:0] rdataR, next_rdataR;
	logic [1:0] rrespR, next_rrespR;
	logic [31:0] loadData, next_loadData;
	logic loadValid, next_loadValid;

	logic doWrite, doRead, txPush, txPop, rxPush, rxPop, txFull, txEmpty, rxFull, rxEmpty;
	logic [31:0] wMerged;

	// ----------------------------------------
	// Bus handshakes
	// ----------------------------------------
	assign awready = !awHave && !bvalidR;
	assign wready = !wHave && !bvalidR;
	assign arready = !rvalidR;
	assign bvalid = bvalidR;
	assign bresp = brespR;
	assign rvalid = rvalidR;
	assign rdata = rdataR;
	assign rresp = rrespR;
	assign loadWord = '{valid: loadValid, data: loadData};

	assign txFull = txCount == (AW+1)'(DEPTH);
	assign txEmpty = txCount == '0;
	assign rxFull = rxCount == (AW+1)'(DEPTH);
	assign rxEmpty = rxCount == '0;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// ----------------------------------------
	// Event conditions and gating
	// ----------------------------------------
	always_comb begin
		cond = '0;
		cond[`BIT_DMA_BUS_ERR] = events.dmaBusErr;
		cond[`BIT_PACKET_DONE] = events.packetDone;
		cond[`BIT_DESCRIPTOR_DONE] = events.descriptorDone;
		cond[`BIT_CTRL_THR] = events.ctrlThreshold;
		cond[`BIT_CTRL_EMPTY] = events.ctrlEmpty;
		cond[`BIT_CTRL_FULL] = events.ctrlFull;
		cond[`BIT_RX_THR] = rxCount >= (AW+1)'(RX_THRESHOLD);
		cond[`BIT_RX_FULL] = rxFull;
		cond[`BIT_RX_EMPTY] = rxEmpty;
		cond[`BIT_TX_THR] = txCount <= (AW+1)'(TX_THRESHOLD);
		cond[`BIT_TX_FULL] = txFull;
		cond[`BIT_TX_EMPTY] = txEmpty;
	end

	// Each signal is its live condition and its enable bit
	genvar g;
	generate
		for (g = 0; g < `SIG_EN_BITS; g++) begin : gateGen
			assign intSignals[g] = cond[g] & sigEn[g];
		end
	endgenerate

	assign irq = |(intStatus & intMask);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_txMem = txMem;
		next_rxMem = rxMem;
		next_txRd = txRd;
		next_txWr = txWr;
		next_rxRd = rxRd;
		next_rxWr = rxWr;
		next_txCount = txCount;
		next_rxCount = rxCount;
		next_txLast = txLast;
		next_rxHead = rxHead;
		next_sigEn = sigEn;
		next_intMask = intMask;
		next_intStatus = intStatus;
		next_awAddrHold = awAddrHold;
		next_awHave = awHave;
		next_wDataHold = wDataHold;
		next_wStrbHold = wStrbHold;
		next_wHave = wHave;
		next_bvalidR = bvalidR;
		next_brespR = brespR;
		next_rvalidR = rvalidR;
		next_rdataR = rdataR;
		next_rrespR = rrespR;
		next_loadData = loadData;
		next_loadValid = loadValid;
		txPush = 1'b0;
		rxPop = 1'b0;
		wMerged = '0;

		if (awvalid && awready) begin
			next_awAddrHold = awaddr;
			next_awHave = 1'b1;
		end
		if (wvalid && wready) begin
			next_wDataHold = wdata;
			next_wStrbHold = wstrb;
			next_wHave = 1'b1;
		end
		if (bvalidR && bready) begin
			next_bvalidR = 1'b0;
		end
		doWrite = awHave && wHave && !bvalidR;
		if (doWrite) begin
			next_awHave = 1'b0;
			next_wHave = 1'b0;
			next_bvalidR = 1'b1;
			next_brespR = `RESP_OKAY;
			if (awAddrHold == `OFS_TX_COMMAND_WORD) begin
				wMerged = merge(txLast, wDataHold, wStrbHold);
				if (txFull) begin
					// Overflowing word is dropped and flagged
					next_brespR = `RESP_SLVERR;
				end else begin
					txPush = 1'b1;
					next_txLast = wMerged;
				end
			end else if (awAddrHold == `OFS_INT_SIG_EN) begin
				wMerged = merge(32'(sigEn), wDataHold, wStrbHold);
				next_sigEn = wMerged[`SIG_EN_BITS-1:0];
			end else if (awAddrHold == `OFS_INT_MASK) begin
				wMerged = merge(32'(intMask), wDataHold, wStrbHold);
				next_intMask = wMerged[`SIG_EN_BITS-1:0];
			end else if (awAddrHold == `OFS_INT_STATUS) begin
				wMerged = merge(`RST_WORD, wDataHold, wStrbHold);
				next_intStatus = intStatus & ~wMerged[`SIG_EN_BITS-1:0];
			end else if (awAddrHold == `OFS_RX_WORD || awAddrHold == `OFS_BUF_LEVELS) begin
				next_brespR = `RESP_OKAY;
			end else begin
				next_brespR = `RESP_SLVERR;
			end
		end

		if (rvalidR && rready) begin
			next_rvalidR = 1'b0;
		end
		doRead = arvalid && arready;
		if (doRead) begin
			next_rvalidR = 1'b1;
			next_rrespR = `RESP_OKAY;
			next_rdataR = `RST_WORD;
			if (araddr == `OFS_TX_COMMAND_WORD) begin
				next_rdataR = txLast;
			end else if (araddr == `OFS_RX_WORD) begin
				next_rdataR = rxHead;
				rxPop = !rxEmpty;
			end else if (araddr == `OFS_INT_SIG_EN) begin
				next_rdataR = 32'(sigEn);
			end else if (araddr == `OFS_INT_MASK) begin
				next_rdataR = 32'(intMask);
			end else if (araddr == `OFS_INT_STATUS) begin
				next_rdataR = 32'(intStatus);
			end else if (araddr == `OFS_BUF_LEVELS) begin
				next_rdataR[`LEVEL_TX_LSB +: AW+1] = txCount;
				next_rdataR[`LEVEL_RX_LSB +: AW+1] = rxCount;
			end else begin
				next_rrespR = `RESP_SLVERR;
			end
		end

		// Transmit queue toward the shift register
		txPop = loadValid && loadTaken;
		if (txPop) begin
			next_loadValid = 1'b0;
		end
		if (txPush) begin
			next_txMem[txWr] = wMerged;
			next_txWr = AW'((txWr + 1'b1) % DEPTH);
		end
		if (!txEmpty && (!loadValid || txPop)) begin
			next_loadData = txMem[txRd];
			next_loadValid = 1'b1;
			next_txRd = AW'((txRd + 1'b1) % DEPTH);
		end
		next_txCount = txCount + (AW+1)'(txPush) - (AW+1)'(!txEmpty && (!loadValid || txPop));

		// Receive FIFO; a word arriving while full is lost unless a read pops a word in the same cycle
		rxPush = transferDone && (!rxFull || rxPop);
		if (rxPush) begin
			next_rxMem[rxWr] = shiftIn;
			next_rxWr = AW'((rxWr + 1'b1) % DEPTH);
		end
		if (rxPop) begin
			next_rxRd = AW'((rxRd + 1'b1) % DEPTH);
		end
		next_rxCount = rxCount + (AW+1)'(rxPush) - (AW+1)'(rxPop);
		// Head kept registered so the read data is a flop
		if (next_rxCount == '0) begin
			next_rxHead = `RST_WORD;
		end else if (rxCount == '0 || (rxPop && next_rxCount == 1 && rxPush && rxCount == 1)) begin
			next_rxHead = rxPush ? shiftIn : next_rxMem[next_rxRd];
		end else begin
			next_rxHead = next_rxMem[next_rxRd];
		end

		// Sticky status, set wins over clear
		next_intStatus = next_intStatus | intSignals;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				txMem[i] <= `RST_WORD;
				rxMem[i] <= `RST_WORD;
			end
			txRd <= '0;
			txWr <= '0;
			rxRd <= '0;
			rxWr <= '0;
			txCount <= '0;
			rxCount <= '0;
			txLast <= `RST_WORD;
			rxHead <= `RST_WORD;
			sigEn <= '0;
			intStatus <= '0;
			intMask <= '0;
			awAddrHold <= '0;
			awHave <= 1'b0;
			wDataHold <= `RST_WORD;
			wStrbHold <= '0;
			wHave <= 1'b0;
			bvalidR <= 1'b0;
			brespR <= `RESP_OKAY;
			rvalidR <= 1'b0;
			rdataR <= `RST_WORD;
			rrespR <= `RESP_OKAY;
			loadData <= `RST_WORD;
			loadValid <= 1'b0;
		end else begin
			txMem <= next_txMem;
			rxMem <= next_rxMem;
			txRd <= next_txRd;
			txWr <= next_txWr;
			rxRd <= next_rxRd;
			rxWr <= next_rxWr;
			txCount <= next_txCount;
			rxCount <= next_rxCount;
			txLast <= next_txLast;
			rxHead <= next_rxHead;
			sigEn <= next_sigEn;
			intStatus <= next_intStatus;
			intMask <= next_intMask;
			awAddrHold <= next_awAddrHold;
			awHave <= next_awHave;
			wDataHold <= next_wDataHold;
			wStrbHold <= next_wStrbHold;
			wHave <= next_wHave;
			bvalidR <= next_bvalidR;
			brespR <= next_brespR;
			rvalidR <= next_rvalidR;
			rdataR <= next_rdataR;
			rrespR <= next_rrespR;
			loadData <= next_loadData;
			loadValid <= next_loadValid;
		end
	end
endmodule : quad_serial_buffers

/* File: rtl/qsi_buffers_regs.svh */
// Register offsets, field positions, reset values and sizes of the serial buffer block
`ifndef QSI_BUFFERS_REGS_SVH
`define QSI_BUFFERS_REGS_SVH
`define OFS_TX_COMMAND_WORD 8'h00
`define OFS_RX_WORD 8'h04
`define OFS_INT_SIG_EN 8'h08
`define OFS_INT_STATUS 8'h0C
`define OFS_INT_MASK 8'h10
`define OFS_BUF_LEVELS 8'h14
`define RST_WORD 32'h0000_0000
`define SIG_EN_BITS 12
`define BIT_DMA_BUS_ERR 11
`define BIT_PACKET_DONE 10
`define BIT_DESCRIPTOR_DONE 9
`define BIT_CTRL_THR 8
`define BIT_CTRL_EMPTY 7
`define BIT_CTRL_FULL 6
`define BIT_RX_THR 5
`define BIT_RX_FULL 4
`define BIT_RX_EMPTY 3
`define BIT_TX_THR 2
`define BIT_TX_FULL 1
`define BIT_TX_EMPTY 0
`define QUEUE_DEPTH 8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define LEVEL_TX_LSB 0
`define LEVEL_RX_LSB 8
`endif

/* File: rtl/qsi_buffers_pkg.sv */
// Types shared by the serial buffer block
package qsi_buffers_pkg;
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} word_t;
	typedef struct packed {
		logic dmaBusErr;
		logic packetDone;
		logic descriptorDone;
		logic ctrlThreshold;
		logic ctrlEmpty;
		logic ctrlFull;
	} ext_events_t;
endpackage : qsi_buffers_pkg

/* File: tb/quad_serial_buffers_monitor.sv */
// Concurrent checks on the ports of the serial buffer block
module quad_serial_buffers_monitor (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire qsi_buffers_pkg::word_t loadWord,
	input wire logic loadTaken,
	input wire qsi_buffers_pkg::ext_events_t events,
	input wire logic [11:0] intSignals
);
	import qsi_buffers_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ----------------
	// Checks
	// ----------------
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped early");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
	read_answer_a: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
	write_block_a: assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
	err_zero_a: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0) else $error("error read not zero");
	load_hold_a: assert property (loadWord.valid && !loadTaken |=> loadWord.valid && $stable(loadWord.data))
		else $error("load word moved before taken");
	dma_gate_a: assert property (intSignals[11] |-> events.dmaBusErr) else $error("dma signal without event");
	done_gate_a: assert property ((intSignals[10:9] & ~{events.packetDone, events.descriptorDone}) == 2'h0)
		else $error("done signal without event");
	ctrl_gate_a: assert property ((intSignals[8:6] & ~{events.ctrlThreshold, events.ctrlEmpty, events.ctrlFull}) == 3'h0)
		else $error("control signal without event");
	reset_quiet_a: assert property ($rose(arst_n) |-> intSignals == 12'h000) else $error("signal after reset");
	cover property (loadWord.valid && loadTaken);
	cover property (rvalid && rresp == 2'b10);
	cover property (intSignals[11]);
endmodule : quad_serial_buffers_monitor

/* File: tb/shift_reg_model.sv */
// Far-side shift register model: takes command words, answers with their inverse
module shift_reg_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire qsi_buffers_pkg::word_t loadWord,
	input wire logic stall,
	output logic loadTaken,
	output logic [31:0] shiftIn,
	output logic transferDone
);
	import qsi_buffers_pkg::*;
	logic [31:0] held;
	logic [31:0] tick;
	logic [2:0] cnt;
	// Stall lets the bench hold the queue full
	assign loadTaken = loadWord.valid && !stall && cnt == 3'h0;
	assign transferDone = cnt == 3'h1;
	// Idle data wanders so stale words cannot pass
	assign shiftIn = transferDone ? held : tick;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 3'h0;
			held <= 32'h0;
			tick <= 32'h0;
		end else begin
			tick <= tick + 32'h1;
			if (loadTaken) begin
				cnt <= 3'h4;
				held <= ~loadWord.data;
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
			end
		end
	end
endmodule : shift_reg_model

/* File: tb/quad_serial_buffers_bench.sv */
// Self-checking bench for the serial buffer block
`include "qsi_buffers_regs.svh"
module quad_serial_buffers_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import qsi_buffers_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic stall = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	ext_events_t events = '0;
	logic awready, wready, bvalid, arready, rvalid, loadTaken, transferDone, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, shiftIn, seed;
	logic [31:0] w [10];
	logic [11:0] intSignals;
	word_t loadWord;
	logic [1:0] bq [$];
	logic [33:0] rq [$];
	logic [33:0] ex;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	quad_serial_buffers dut (
		.clk(clk),
		.arst_n(arst_n),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.loadWord(loadWord),
		.loadTaken(loadTaken),
		.shiftIn(shiftIn),
		.transferDone(transferDone),
		.events(events),
		.intSignals(intSignals),
		.irq(irq)
	);
	shift_reg_model far (
		.clk(clk),
		.arst_n(arst_n),
		.loadWord(loadWord),
		.stall(stall),
		.loadTaken(loadTaken),
		.shiftIn(shiftIn),
		.transferDone(transferDone)
	);
	initial begin
		forever #20 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task report_and_stop;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	// ----------------
	// Bus master
	// ----------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ah, wh, bh;
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			@(posedge clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
		bready <= 1'b0;
		// One idle edge so a following call never re-raises bready in the same step
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
		logic ah, dh;
		rq.push_back({r, e});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ah = arvalid && arready;
			dh = rvalid;
			@(posedge clk);
			if (ah) arvalid <= 1'b0;
		end while (!dh);
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	// Output is read at the falling edge, never in the step of the edge that launches it
	task automatic look(input string nm, input logic [31:0] e);
		logic [31:0] g;
		@(negedge clk);
		if (nm == "irq") begin
			g = {31'h0, irq};
		end else if (nm == "loadWord") begin
			g = loadWord.data;
		end else begin
			g = {20'h0, intSignals};
		end
		chk(nm, e, g);
		@(posedge clk);
	endtask : look
	// Answers are compared where they appear, oldest note first
	always @(negedge clk) begin
		if (bvalid && bready) chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
		if (rvalid && rready) begin
			ex = rq.pop_front();
			chk("rresp", {30'h0, ex[33:32]}, {30'h0, rresp});
			chk("rdata", ex[31:0], rdata);
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		seed = 32'h0000002B;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		look("intSignals", 32'h0);
		rd(`OFS_TX_COMMAND_WORD, 32'h0);
		rd(`OFS_RX_WORD, 32'h0);
		rd(`OFS_INT_SIG_EN, 32'h0);
		rd(8'h20, 32'h0, 2'b10);
		wr(8'h20, 32'h1, 2'b10);
		wr(`OFS_INT_SIG_EN, 32'hFFFFFFFF, 2'b00);
		rd(`OFS_INT_SIG_EN, 32'h00000FFF);
		// Idle queues: tx empty, tx threshold and rx empty stay live (0x00D)
		for (int b = 6; b < 12; b++) begin
			events <= ext_events_t'(6'h01 << (b - 6));
			wr(`OFS_INT_SIG_EN, 32'hFFF ^ (32'h1 << b), 2'b00);
			look("intSignals", 32'h00D);
			wr(`OFS_INT_SIG_EN, 32'hFFF, 2'b00);
			look("intSignals", 32'h00D | (32'h1 << b));
		end
		events <= '0;
		wr(`OFS_INT_MASK, 32'h800, 2'b00);
		wr(`OFS_INT_STATUS, 32'hFFF, 2'b00);
		look("irq", 32'h0);
		events.dmaBusErr <= 1'b1;
		@(posedge clk);
		events <= '0;
		look("irq", 32'h1);
		wr(`OFS_INT_MASK, 32'h0, 2'b00);
		look("irq", 32'h0);
		wr(`OFS_INT_MASK, 32'h800, 2'b00);
		look("irq", 32'h1);
		wr(`OFS_INT_STATUS, 32'h800, 2'b00);
		look("irq", 32'h0);
		stall <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			w[i] = seed;
			wr(`OFS_TX_COMMAND_WORD, seed, i < 9 ? 2'b00 : 2'b10);
		end
		rd(`OFS_BUF_LEVELS, 32'h8);
		rd(`OFS_TX_COMMAND_WORD, w[8]);
		look("loadWord", w[0]);
		look("intSignals", 32'h00A);
		stall <= 1'b0;
		n = 0;
		repeat (400) begin
			@(negedge clk);
			if (transferDone === 1'b1) n++;
			if (n == 9) break;
		end
		@(posedge clk);
		rd(`OFS_BUF_LEVELS, 32'h800);
		look("intSignals", 32'h035);
		for (int i = 0; i < 8; i++) rd(`OFS_RX_WORD, ~w[i]);
		rd(`OFS_RX_WORD, 32'h0);
		report_and_stop();
	end
endmodule : quad_serial_buffers_bench
bind quad_serial_buffers quad_serial_buffers_monitor mon (
	.clk(clk),
	.arst_n(arst_n),
	.awready(awready),
	.wready(wready),
	.bvalid(bvalid),
	.bready(bready),
	.arvalid(arvalid),
	.arready(arready),
	.rdata(rdata),
	.rresp(rresp),
	.rvalid(rvalid),
	.rready(rready),
	.loadWord(loadWord),
	.loadTaken(loadTaken),
	.events(events),
	.intSignals(intSignals)
);
